// ==== verilog/asrs_analog_speed_ref_select.sv ====
// Analog frequency command source, range and reversal selection
`timescale 1ns/100ps
`include "asrs_defs.svh"

module asrs_analog_speed_ref_select
  import asrs_pkg::*;
#(
  parameter int NT = 5
)
(
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire logic [13:0]   extended_display_selection,
  input  wire logic          range_wr,
  input  wire logic [6:0]    range_wdata,
  input  wire logic          t4_type_wr,
  input  wire logic [1:0]    t4_type_wdata,
  input  wire logic          t2_gain_wr,
  input  wire logic          t4_gain_wr,
  input  wire logic [15:0]   gain_wdata,
  input  wire logic [13:0]   thermistor_protection_level,
  input  wire logic [NT*8-1:0] input_terminal_function_select,
  input  wire logic [NT-1:0] terminal_pin,
  input  wire logic          vi_switch_voltage,
  input  wire logic [14:0]   t2_reading,
  input  wire logic [14:0]   t4_reading,
  input  wire logic [15:0]   accel_ref_frequency,
  output logic [6:0]         analog_range_setting,
  output logic [1:0]         terminal4_type_setting,
  output logic [15:0]        terminal2_gain_frequency,
  output logic [15:0]        terminal4_gain_frequency,
  output logic               terminal4_select_input,
  output logic               t2_source,
  output logic               t4_source,
  output logic               t4_voltage,
  output logic               setting_mismatch,
  output logic               reversible,
  output logic               t2_range_10v,
  output logic [15:0]        slope_ref_frequency,
  output logic [15:0]        freq_cmd,
  output logic               reverse_dir,
  output logic               cmd_valid
);

  typedef struct packed {
    logic [NT-1:0]  pin_s1;
    logic [NT-1:0]  pin_s2;
    logic [NT-1:0]  pin_s3;
    logic [NT-1:0]  pin_filt;
    logic           sw_s1;
    logic           sw_s2;
    logic           sw_s3;
    logic           sw_filt;
    logic [6:0]     range;
    logic [1:0]     t4_type;
    logic [15:0]    t2_gain;
    logic [15:0]    t4_gain;
    logic           au;
    logic           t2_src;
    logic           t4_src;
    logic           t4_volt;
    logic           mismatch;
    logic           reversible;
    logic           t2_10v;
    logic [15:0]    slope_ref;
    asrs_state_type state;
    logic [15:0]    cmd_gain;
    logic           cmd_rev;
    logic           cmd_zero;
    logic [15:0]    freq_cmd;
    logic           reverse_dir;
    logic           cmd_valid;
  } asrs_regs_type;

  localparam asrs_regs_type ASRS_REGS_RST = '{
    range:    `ASRS_RANGE_RST,
    t4_type:  `ASRS_T4_TYPE_RST,
    t2_gain:  `ASRS_GAIN_RST,
    t4_gain:  `ASRS_GAIN_RST,
    state:    ASRS_IDLE,
    default:  '0
  };

  asrs_regs_type st_r;
  asrs_regs_type st_nxt;
  logic [NT-1:0] au_match;
  logic [NT-1:0] au_active;
  logic          wr_open;
  logic          range_ok;
  logic [14:0]   rd_x;
  logic [14:0]   full_scale;
  logic [14:0]   pivot;
  logic [14:0]   delta;
  logic [14:0]   span;
  logic          below;
  logic [15:0]   act_gain;
  logic          div_start;
  logic [30:0]   div_num;
  logic          div_done;
  logic [30:0]   div_quo;

  // Per-pin routing of the terminal 4 select function
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_au
      assign au_match[gi]  = input_terminal_function_select[gi*8 +: 8] == `ASRS_AU_FUNC_CODE;
      assign au_active[gi] = au_match[gi] & st_r.pin_filt[gi];
    end
  endgenerate

  assign wr_open = extended_display_selection == `ASRS_EXT_DISPLAY_ALL;
  assign range_ok = (range_wdata == `ASRS_RANGE_10V) || (range_wdata == `ASRS_RANGE_5V) ||
                    (range_wdata == `ASRS_RANGE_10V_REV) || (range_wdata == `ASRS_RANGE_5V_REV);

  // Scaling points of the active input
  always_comb begin
    act_gain = st_r.t4_src ? st_r.t4_gain : st_r.t2_gain;
    if (!st_r.t4_src) begin
      full_scale = st_r.t2_10v ? `ASRS_FS_10V : `ASRS_FS_5V;
      pivot = st_r.reversible ? (full_scale >> 1) : 15'h0000;
    end else if (!st_r.t4_volt) begin
      full_scale = `ASRS_FS_20MA;
      pivot = `ASRS_BIAS_4MA;
    end else begin
      full_scale = (st_r.t4_type == `ASRS_T4_10V) ? `ASRS_FS_10V : `ASRS_FS_5V;
      pivot = st_r.reversible ? (full_scale >> 1) : 15'h0000;
    end
    rd_x = st_r.t4_src ? t4_reading : t2_reading;
    if (rd_x > full_scale) begin
      rd_x = full_scale;
    end
    below = rd_x < pivot;
    if (!below) begin
      delta = rd_x - pivot;
      span = full_scale - pivot;
    end else if (st_r.reversible) begin
      delta = pivot - rd_x;
      span = pivot;
    end else begin
      delta = 15'h0000;
      span = 15'h0001;
    end
    div_num = {15'h0000, act_gain} * {16'h0000, delta};
  end

  always_comb begin
    st_nxt = st_r;
    div_start = 1'b0;
    st_nxt.cmd_valid = 1'b0;
    st_nxt.pin_s1 = terminal_pin;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.pin_s3 = st_r.pin_s2;
    st_nxt.sw_s1 = vi_switch_voltage;
    st_nxt.sw_s2 = st_r.sw_s1;
    st_nxt.sw_s3 = st_r.sw_s2;
    for (int i = 0; i < NT; i++) begin
      if (st_r.pin_s2[i] == st_r.pin_s3[i]) begin
        st_nxt.pin_filt[i] = st_r.pin_s3[i];
      end
    end
    if (st_r.sw_s2 == st_r.sw_s3) begin
      st_nxt.sw_filt = st_r.sw_s3;
    end
    if (range_wr && wr_open && range_ok) begin
      st_nxt.range = range_wdata;
    end
    if (t4_type_wr && wr_open && (t4_type_wdata != 2'h3)) begin
      st_nxt.t4_type = t4_type_wdata;
    end
    if (t2_gain_wr && wr_open && (gain_wdata <= `ASRS_GAIN_MAX)) begin
      st_nxt.t2_gain = gain_wdata;
    end
    if (t4_gain_wr && wr_open && (gain_wdata <= `ASRS_GAIN_MAX)) begin
      st_nxt.t4_gain = gain_wdata;
    end
    st_nxt.reversible = (st_r.range == `ASRS_RANGE_10V_REV) ||
                        (st_r.range == `ASRS_RANGE_5V_REV);
    st_nxt.t2_10v = (st_r.range == `ASRS_RANGE_10V) ||
                    (st_r.range == `ASRS_RANGE_10V_REV);
    st_nxt.au = |au_active;
    st_nxt.t4_src = st_r.au;
    st_nxt.t2_src = !st_r.au &&
                    (thermistor_protection_level == `ASRS_THERM_DISABLE);
    st_nxt.t4_volt = (st_r.t4_type != `ASRS_T4_CURRENT) && st_r.sw_filt;
    st_nxt.mismatch = (st_r.t4_type == `ASRS_T4_CURRENT) == st_r.sw_filt;
    // Slope reference follows its own setting only, never the range
    st_nxt.slope_ref = accel_ref_frequency;
    case (st_r.state)
      ASRS_IDLE: begin
        div_start = 1'b1;
        st_nxt.cmd_gain = act_gain;
        st_nxt.cmd_rev = below && st_r.reversible;
        // A mis-set terminal 4 switch yields a zero command while terminal 4 is the source
        st_nxt.cmd_zero = !(st_r.t2_src || st_r.t4_src) || (st_r.t4_src && st_r.mismatch);
        st_nxt.state = ASRS_DIV;
      end
      ASRS_DIV: begin
        if (div_done) begin
          st_nxt.state = ASRS_IDLE;
          st_nxt.cmd_valid = 1'b1;
          st_nxt.reverse_dir = st_r.cmd_zero ? 1'b0 : st_r.cmd_rev;
          if (st_r.cmd_zero) begin
            st_nxt.freq_cmd = 16'h0000;
          end else if (div_quo > {15'h0000, st_r.cmd_gain}) begin
            st_nxt.freq_cmd = st_r.cmd_gain;
          end else begin
            st_nxt.freq_cmd = div_quo[15:0];
          end
        end
      end
      default: begin
        st_nxt.state = ASRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r <= ASRS_REGS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  asrs_divider #(
    .NW (31),
    .DW (15)
  ) u_div (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .start       (div_start),
    .numerator   (div_num),
    .denominator (span),
    .done        (div_done),
    .quotient    (div_quo)
  );

  assign analog_range_setting     = st_r.range;
  assign terminal4_type_setting   = st_r.t4_type;
  assign terminal2_gain_frequency = st_r.t2_gain;
  assign terminal4_gain_frequency = st_r.t4_gain;
  assign terminal4_select_input   = st_r.au;
  assign t2_source                = st_r.t2_src;
  assign t4_source                = st_r.t4_src;
  assign t4_voltage               = st_r.t4_volt;
  assign setting_mismatch         = st_r.mismatch;
  assign reversible               = st_r.reversible;
  assign t2_range_10v             = st_r.t2_10v;
  assign slope_ref_frequency      = st_r.slope_ref;
  assign freq_cmd                 = st_r.freq_cmd;
  assign reverse_dir              = st_r.reverse_dir;
  assign cmd_valid                = st_r.cmd_valid;

  range_decode_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    ($past(st_r.range) == `ASRS_RANGE_5V_REV) |-> (reversible && !t2_range_10v))
    else $error("range code 11 not decoded as reversible 0-5 V");

  range_reset_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    $past(reset) |-> (analog_range_setting == `ASRS_RANGE_5V) && !reversible)
    else $error("range not at 0-5 V without reversal after reset");

  t4_volt_type_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    t4_voltage |-> ($past(st_r.t4_type) != `ASRS_T4_CURRENT) && $past(st_r.sw_filt))
    else $error("terminal 4 voltage without voltage type and switch");

  source_excl_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    t4_source |-> !t2_source ##0 ($past(terminal4_select_input) == t4_source))
    else $error("terminal 2 and terminal 4 selected together");

  au_routing_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (au_match == '0) ##1 (au_match == '0) |-> !terminal4_select_input)
    else $error("terminal 4 select without a routed pin");

  therm_block_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (thermistor_protection_level != `ASRS_THERM_DISABLE) |=> !t2_source)
    else $error("terminal 2 accepted with thermistor level set");

  write_lock_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!wr_open && !$past(reset)) |=> $stable(analog_range_setting) &&
                                    $stable(terminal4_type_setting))
    else $error("setting changed while extended display is not 0");

  gain_limit_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (terminal2_gain_frequency <= `ASRS_GAIN_MAX) && (terminal4_gain_frequency <= `ASRS_GAIN_MAX))
    else $error("gain frequency above 400 Hz");

  cmd_bound_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    cmd_valid |-> (freq_cmd <= $past(st_r.cmd_gain)))
    else $error("frequency command above gain frequency");

  reverse_gate_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (cmd_valid && reverse_dir) |-> $past(st_r.cmd_rev) && !$past(st_r.cmd_zero))
    else $error("reverse command without reversible low reading");

  cmd_period_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    cmd_valid |=> !cmd_valid [*8] ##[1:40] cmd_valid)
    else $error("frequency command update period wrong");

  slope_keep_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    $changed(analog_range_setting) && $stable(accel_ref_frequency) |=> $stable(slope_ref_frequency))
    else $error("slope reference moved with range change");

endmodule

// ==== verilog/asrs_defs.svh ====
// Constants for the analog speed reference selector
`ifndef ASRS_DEFS_SVH
`define ASRS_DEFS_SVH

// Analog range setting codes (decimal 0, 1, 10, 11)
`define ASRS_RANGE_10V      7'h00
`define ASRS_RANGE_5V       7'h01
`define ASRS_RANGE_10V_REV  7'h0a
`define ASRS_RANGE_5V_REV   7'h0b
`define ASRS_RANGE_RST      7'h01

// Terminal 4 type setting codes
`define ASRS_T4_CURRENT     2'h0
`define ASRS_T4_5V          2'h1
`define ASRS_T4_10V         2'h2
`define ASRS_T4_TYPE_RST    2'h0

// Gain frequency in 0.01 Hz units: 50 Hz reset, 400 Hz ceiling
`define ASRS_GAIN_RST       16'h1388
`define ASRS_GAIN_MAX       16'h9c40

// Thermistor level that leaves terminal 2 usable
`define ASRS_THERM_DISABLE  14'h270f

// Input function code that routes the terminal-4 select
`define ASRS_AU_FUNC_CODE   8'h04

// Extended display value that opens the settings for writing
`define ASRS_EXT_DISPLAY_ALL 14'h0000

// Reading scale points: mV for voltage, uA for current
`define ASRS_FS_5V          15'h1388
`define ASRS_FS_10V         15'h2710
`define ASRS_FS_20MA        15'h4e20
`define ASRS_BIAS_4MA       15'h0fa0

`endif

// ==== verilog/asrs_pkg.sv ====
// Types shared by the analog speed reference selector
package asrs_pkg;

  typedef enum logic [0:0] {
    ASRS_IDLE,
    ASRS_DIV
  } asrs_state_type;

  typedef enum logic [0:0] {
    ASRS_DV_IDLE,
    ASRS_DV_RUN
  } asrs_div_state_type;

endpackage

// ==== verilog/asrs_divider.sv ====
// Serial restoring divider for the frequency command scaling
`timescale 1ns/100ps

module asrs_divider
  import asrs_pkg::*;
#(
  parameter int NW = 31,
  parameter int DW = 15
)
(
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire logic          start,
  input  wire logic [NW-1:0] numerator,
  input  wire logic [DW-1:0] denominator,
  output logic               done,
  output logic [NW-1:0]      quotient
);

  typedef struct packed {
    asrs_div_state_type state;
    logic [5:0]         cnt;
    logic [DW-1:0]      rem;
    logic [NW-1:0]      quo;
    logic [DW-1:0]      den;
    logic               done;
  } asrs_div_regs_type;

  asrs_div_regs_type st_r;
  asrs_div_regs_type st_nxt;
  logic [DW:0]       trial;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    trial = {st_r.rem, st_r.quo[NW-1]};
    case (st_r.state)
      ASRS_DV_IDLE: begin
        if (start) begin
          st_nxt.state = ASRS_DV_RUN;
          st_nxt.cnt = 6'(NW);
          st_nxt.rem = '0;
          st_nxt.quo = numerator;
          st_nxt.den = denominator;
        end
      end
      ASRS_DV_RUN: begin
        if (trial >= {1'b0, st_r.den}) begin
          st_nxt.rem = DW'(trial - {1'b0, st_r.den});
          st_nxt.quo = {st_r.quo[NW-2:0], 1'b1};
        end else begin
          st_nxt.rem = trial[DW-1:0];
          st_nxt.quo = {st_r.quo[NW-2:0], 1'b0};
        end
        st_nxt.cnt = st_r.cnt - 6'h01;
        if (st_r.cnt == 6'h01) begin
          st_nxt.state = ASRS_DV_IDLE;
          st_nxt.done = 1'b1;
        end
      end
      default: begin
        st_nxt.state = ASRS_DV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
  assign quotient = st_r.quo;

endmodule

// ==== verif/asrs_analog_source.sv ====
// Behavioural analog source that feeds both terminal readings
`timescale 1ns/100ps

module asrs_analog_source (
  input  wire logic        clk_sys,
  input  wire logic [14:0] t2_level,
  input  wire logic [14:0] t4_level,
  output logic      [14:0] t2_reading,
  output logic      [14:0] t4_reading
);
  // Readings follow the level one clock later, like a settled converter sample
  always_ff @(posedge clk_sys) begin
    t2_reading <= t2_level;
    t4_reading <= t4_level;
  end
endmodule

// ==== verif/asrs_analog_speed_ref_select_test.sv ====
// Self-checking bench for the analog speed reference selector
`timescale 1ns/100ps

module asrs_analog_speed_ref_select_test;
  typedef struct packed {
    logic [6:0]  rng;
    logic [1:0]  typ;
    logic        sw;
    logic        au;
    logic [13:0] therm;
    logic [14:0] t2;
    logic [14:0] t4;
    logic [15:0] freq;
    logic        rev;
    logic        t4src;
  } asrs_row_type;

  localparam logic [13:0] T = 14'h270f;
  logic        clk_sys, reset, range_wr, t4_type_wr, t2_gain_wr, t4_gain_wr;
  logic [13:0] extended_display_selection, thermistor_protection_level;
  logic [6:0]  range_wdata, analog_range_setting;
  logic [1:0]  t4_type_wdata, terminal4_type_setting;
  logic [15:0] gain_wdata, accel_ref_frequency, terminal2_gain_frequency;
  logic [15:0] terminal4_gain_frequency, slope_ref_frequency, freq_cmd;
  logic [39:0] input_terminal_function_select;
  logic [4:0]  terminal_pin;
  logic [14:0] t2_level, t4_level, t2_reading, t4_reading;
  logic        vi_switch_voltage, terminal4_select_input, t2_source, t4_source;
  logic        t4_voltage, reversible, t2_range_10v, reverse_dir, cmd_valid;
  logic        setting_mismatch;
  int          err_total, cmp_count;
  asrs_row_type rows [11];

  asrs_analog_source asrs_analog_source_inst (.clk_sys, .t2_level, .t4_level,
    .t2_reading, .t4_reading);

  asrs_analog_speed_ref_select #(.NT(5)) asrs_analog_speed_ref_select_inst (
    .clk_sys, .reset, .extended_display_selection, .range_wr, .range_wdata,
    .t4_type_wr, .t4_type_wdata, .t2_gain_wr, .t4_gain_wr, .gain_wdata,
    .thermistor_protection_level, .input_terminal_function_select, .terminal_pin,
    .vi_switch_voltage, .t2_reading, .t4_reading, .accel_ref_frequency,
    .analog_range_setting, .terminal4_type_setting, .terminal2_gain_frequency,
    .terminal4_gain_frequency, .terminal4_select_input, .t2_source, .t4_source,
    .t4_voltage, .setting_mismatch, .reversible, .t2_range_10v,
    .slope_ref_frequency, .freq_cmd, .reverse_dir, .cmd_valid);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Strobe one setting: 0 range, 1 terminal 4 type, 2 and 3 gains
  task automatic wr(input logic [1:0] sel, input logic [15:0] d);
    @(posedge clk_sys);
    range_wr      <= (sel == 2'h0);
    t4_type_wr    <= (sel == 2'h1);
    t2_gain_wr    <= (sel == 2'h2);
    t4_gain_wr    <= (sel == 2'h3);
    range_wdata   <= d[6:0];
    t4_type_wdata <= d[1:0];
    gain_wdata    <= d;
    @(posedge clk_sys);
    range_wr      <= 1'b0;
    t4_type_wr    <= 1'b0;
    t2_gain_wr    <= 1'b0;
    t4_gain_wr    <= 1'b0;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_cmd;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (cmd_valid !== 1'b1 && n < 200);
    if (n >= 200) begin
      err_total++;
      $display("[FAIL] cmd_valid expected 1 seen none");
      complete_run;
    end
  endtask

  // Second pulse comes from a snapshot taken after the inputs settled
  task automatic apply(input asrs_row_type r);
    wr(2'h0, 16'(r.rng));
    wr(2'h1, 16'(r.typ));
    thermistor_protection_level <= r.therm;
    terminal_pin                <= {2'h0, r.au, 2'h0};
    vi_switch_voltage           <= r.sw;
    t2_level                    <= r.t2;
    t4_level                    <= r.t4;
    repeat (10) @(posedge clk_sys);
    wait_cmd;
    wait_cmd;
    #1;
  endtask

  initial begin
    err_total = 0;
    cmp_count = 0;
    reset = 1'b1;
    {range_wr, t4_type_wr, t2_gain_wr, t4_gain_wr, vi_switch_voltage} = '0;
    {range_wdata, t4_type_wdata, gain_wdata, terminal_pin} = '0;
    extended_display_selection = 14'h0000;
    thermistor_protection_level = T;
    input_terminal_function_select = 40'h0000040000;
    t2_level = 15'h0000;
    t4_level = 15'h0000;
    accel_ref_frequency = 16'h0000;
    rows = '{
      '{7'h01, 2'h0, 1'b0, 1'b0, T, 15'h09c4, 15'h0000, 16'h09c4, 1'b0, 1'b0},
      '{7'h00, 2'h0, 1'b0, 1'b0, T, 15'h1388, 15'h0000, 16'h09c4, 1'b0, 1'b0},
      '{7'h00, 2'h0, 1'b0, 1'b0, T, 15'h2710, 15'h0000, 16'h1388, 1'b0, 1'b0},
      '{7'h0b, 2'h0, 1'b0, 1'b0, T, 15'h04e2, 15'h0000, 16'h09c4, 1'b1, 1'b0},
      '{7'h0a, 2'h0, 1'b0, 1'b0, T, 15'h2710, 15'h0000, 16'h1388, 1'b0, 1'b0},
      '{7'h01, 2'h0, 1'b0, 1'b1, T, 15'h1388, 15'h2ee0, 16'h09c4, 1'b0, 1'b1},
      '{7'h0b, 2'h0, 1'b0, 1'b1, T, 15'h1388, 15'h07d0, 16'h09c4, 1'b1, 1'b1},
      '{7'h01, 2'h1, 1'b1, 1'b1, T, 15'h1388, 15'h1388, 16'h1388, 1'b0, 1'b1},
      '{7'h01, 2'h2, 1'b1, 1'b1, T, 15'h1388, 15'h1388, 16'h09c4, 1'b0, 1'b1},
      '{7'h01, 2'h0, 1'b0, 1'b0, 14'h0000, 15'h1388, 15'h0000, 16'h0000, 1'b0, 1'b0},
      '{7'h01, 2'h1, 1'b0, 1'b1, T, 15'h1388, 15'h1388, 16'h0000, 1'b0, 1'b1}};
    repeat (10) @(posedge clk_sys);
    #1;
    chk("range_rst", 16'(analog_range_setting), 16'h0001);
    chk("type_rst", 16'(terminal4_type_setting), 16'h0000);
    chk("t2_gain_rst", terminal2_gain_frequency, 16'h1388);
    chk("t4_gain_rst", terminal4_gain_frequency, 16'h1388);
    @(posedge clk_sys);
    reset <= 1'b0;
    settle;
    chk("reversible_rst", 16'(reversible), 16'h0000);
    chk("range_10v_rst", 16'(t2_range_10v), 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 11; i++) begin
      apply(rows[i]);
      chk("freq_cmd", freq_cmd, rows[i].freq);
      chk("reverse_dir", 16'(reverse_dir), 16'(rows[i].rev));
      chk("t4_source", 16'(t4_source), 16'(rows[i].t4src));
      chk("t2_source", 16'(t2_source), 16'(!rows[i].t4src && rows[i].therm == T));
      chk("reversible", 16'(reversible), 16'(rows[i].rng[3]));
      chk("range_10v", 16'(t2_range_10v), 16'(!rows[i].rng[0]));
      chk("t4_voltage", 16'(t4_voltage), 16'(rows[i].typ != 2'h0 && rows[i].sw));
      chk("mismatch", 16'(setting_mismatch), 16'((rows[i].typ == 2'h0) == rows[i].sw));
      $display("row %0d done", i);
    end
    extended_display_selection <= 14'h0001;
    wr(2'h0, 16'h000a);
    wr(2'h1, 16'h0002);
    settle;
    chk("range_locked", 16'(analog_range_setting), 16'h0001);
    chk("type_locked", 16'(terminal4_type_setting), 16'h0001);
    extended_display_selection <= 14'h0000;
    wr(2'h0, 16'h0002);
    wr(2'h1, 16'h0003);
    wr(2'h2, 16'h9c41);
    settle;
    chk("range_illegal", 16'(analog_range_setting), 16'h0001);
    chk("type_illegal", 16'(terminal4_type_setting), 16'h0001);
    chk("gain_over", terminal2_gain_frequency, 16'h1388);
    wr(2'h2, 16'h9c40);
    wr(2'h3, 16'h0000);
    settle;
    chk("t2_gain_max", terminal2_gain_frequency, 16'h9c40);
    chk("t4_gain_zero", terminal4_gain_frequency, 16'h0000);
    apply('{7'h01, 2'h0, 1'b0, 1'b0, T, 15'h1388, 15'h0000, 16'h9c40, 1'b0, 1'b0});
    chk("freq_full_scale", freq_cmd, 16'h9c40);
    $display("settings test done");
    @(posedge clk_sys);
    terminal_pin <= 5'h01;
    repeat (10) @(posedge clk_sys);
    #1;
    chk("wrong_pin", 16'(terminal4_select_input), 16'h0000);
    terminal_pin <= 5'h04;
    repeat (10) @(posedge clk_sys);
    #1;
    chk("coded_pin", 16'(terminal4_select_input), 16'h0001);
    input_terminal_function_select <= 40'h0000000000;
    repeat (10) @(posedge clk_sys);
    #1;
    chk("uncoded_pin", 16'(terminal4_select_input), 16'h0000);
    accel_ref_frequency <= 16'h1234;
    wr(2'h0, 16'h000b);
    settle;
    chk("slope_ref", slope_ref_frequency, 16'h1234);
    $display("pin and slope test done");
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("range_mid_rst", 16'(analog_range_setting), 16'h0001);
    chk("t2_gain_mid_rst", terminal2_gain_frequency, 16'h1388);
    chk("freq_mid_rst", freq_cmd, 16'h0000);
    @(posedge clk_sys);
    reset <= 1'b0;
    settle;
    chk("reversible_mid_rst", 16'(reversible), 16'h0000);
    // First command after release is still built from reset state
    wait_cmd;
    wait_cmd;
    chk("freq_after_rst", freq_cmd, 16'h1388);
    $display("mid-run reset test done");
    complete_run;
  end
endmodule
